// >>> core/tic_regs.svh
`ifndef TIC_REGS_SVH
`define TIC_REGS_SVH

// ---------------------------------------------------------------
// register addresses on the special function register bus
// ---------------------------------------------------------------
`define TIC_CTRL_ADDR     8'ha1
`define TIC_HTH_ADDR      8'ha2
`define TIC_SEC_ADDR      8'ha3
`define TIC_MIN_ADDR      8'ha4
`define TIC_HOUR_ADDR     8'ha5
`define TIC_MATCH_ADDR    8'ha6

// ---------------------------------------------------------------
// control register fields and reset values
// ---------------------------------------------------------------
`define TIC_CLKEN_BIT     0
`define TIC_IEN_BIT       1
`define TIC_FLAG_BIT      2
`define TIC_ONESHOT_BIT   3
`define TIC_TBSEL_LO      4
`define TIC_TBSEL_HI      5
`define TIC_HOUR24_BIT    6
`define TIC_CTRL_RESET    8'h00
`define TIC_CTRL_WMASK    8'h7f
`define TIC_MATCH_RESET   8'h00
`define TIC_TIME_RESET    8'h00

// ---------------------------------------------------------------
// time base limits and timing
// ---------------------------------------------------------------
`define TIC_XTAL_HZ       32768
`define TIC_SUBSEC_PER_S  128
`define TIC_PRESCALE      (`TIC_XTAL_HZ / `TIC_SUBSEC_PER_S)
`define TIC_HTH_MAX       8'h7f
`define TIC_SEC_MAX       8'h3b
`define TIC_MIN_MAX       8'h3b
`define TIC_HOUR24_MAX    8'h17
`define TIC_HOUR_FULL_MAX 8'hff
`define TIC_WAKE_VECTOR   16'h0053

`endif

// >>> core/tic_pkg.sv
package tic_pkg;

    // interval counter tap on the time base chain
    typedef enum logic [1:0] {
        TB_SUBSEC = 2'b00,
        TB_SEC    = 2'b01,
        TB_MIN    = 2'b10,
        TB_HOUR   = 2'b11
    } timebase_t;

endpackage

// >>> core/xtal_sync.sv
`timescale 1ns/1ns
`default_nettype none

// ---------------------------------------------------------------
// crystal pin synchroniser with rising edge pulse
// ---------------------------------------------------------------
module xtal_sync (
    input  wire logic clock_i,
    input  wire logic rst_i,
    input  wire logic pin_i,
    output logic      rise_o
);
    logic meta_ff;
    logic s2_ff;
    logic s3_ff;
    logic level_ff;

    // three stages; the first feeds only the second
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            meta_ff <= 1'b0;
            s2_ff   <= 1'b0;
            s3_ff   <= 1'b0;
        end else begin
            meta_ff <= pin_i;
            s2_ff   <= meta_ff;
            s3_ff   <= s2_ff;
        end
    end

    // level moves only once stages two and three agree
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            level_ff <= 1'b0;
            rise_o   <= 1'b0;
        end else begin
            if (s2_ff == s3_ff) begin
                level_ff <= s3_ff;
            end
            rise_o <= (s2_ff == s3_ff) && s3_ff && !level_ff;
        end
    end
endmodule // xtal_sync

`default_nettype wire

// >>> core/time_base.sv
`timescale 1ns/1ns
`default_nettype none
`include "tic_regs.svh"

// ---------------------------------------------------------------
// cascaded sub-second / seconds / minutes / hours chain
// ---------------------------------------------------------------
module time_base #(
    parameter int PRESCALE = `TIC_PRESCALE
) (
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    input  wire logic       tick_i,
    input  wire logic       run_i,
    input  wire logic       hour24_i,
    input  wire logic [7:0] load_hth_i,
    input  wire logic [7:0] load_sec_i,
    input  wire logic [7:0] load_min_i,
    input  wire logic [7:0] load_hour_i,
    output logic      [7:0] hth_o,
    output logic      [7:0] sec_o,
    output logic      [7:0] min_o,
    output logic      [7:0] hour_o,
    output logic      [3:0] ovf_o
);
    localparam int PW = $clog2(PRESCALE);

    logic [PW-1:0] pre_ff;
    logic [7:0]    hour_max;

    // >= so an out of range preload still wraps
    function automatic logic at_top(input logic [7:0] v,
                                    input logic [7:0] top);
        at_top = (v >= top);
    endfunction

    function automatic logic [7:0] step(input logic [7:0] v,
                                        input logic [7:0] top);
        step = at_top(v, top) ? 8'h00 : v + 8'h01;
    endfunction

    assign hour_max = hour24_i ? `TIC_HOUR24_MAX : `TIC_HOUR_FULL_MAX;

    // carry chain; each stage fires on the previous stage's wrap
    always_comb begin
        ovf_o[0] = run_i && tick_i && (pre_ff == PW'(PRESCALE - 1));
        ovf_o[1] = ovf_o[0] && at_top(hth_o, `TIC_HTH_MAX);
        ovf_o[2] = ovf_o[1] && at_top(sec_o, `TIC_SEC_MAX);
        ovf_o[3] = ovf_o[2] && at_top(min_o, `TIC_MIN_MAX);
    end

    // stopped chain tracks the software values
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            pre_ff <= '0;
            hth_o  <= `TIC_TIME_RESET;
            sec_o  <= `TIC_TIME_RESET;
            min_o  <= `TIC_TIME_RESET;
            hour_o <= `TIC_TIME_RESET;
        end else if (!run_i) begin
            pre_ff <= '0;
            hth_o  <= load_hth_i;
            sec_o  <= load_sec_i;
            min_o  <= load_min_i;
            hour_o <= load_hour_i;
        end else if (tick_i) begin
            pre_ff <= ovf_o[0] ? '0 : pre_ff + PW'(1);
            if (ovf_o[0]) hth_o  <= step(hth_o, `TIC_HTH_MAX);
            if (ovf_o[1]) sec_o  <= step(sec_o, `TIC_SEC_MAX);
            if (ovf_o[2]) min_o  <= step(min_o, `TIC_MIN_MAX);
            if (ovf_o[3]) hour_o <= step(hour_o, hour_max);
        end
    end
endmodule // time_base

`default_nettype wire

// >>> core/long_interval_timer.sv
`timescale 1ns/1ns
`default_nettype none
`include "tic_regs.svh"

module long_interval_timer
    import tic_pkg::*;
#(
    parameter int PRESCALE = `TIC_PRESCALE
) (
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic        xtal_i,
    input  wire logic        power_down_i,
    input  wire logic        int_enable_i,
    input  wire logic [7:0]  sfr_addr_i,
    input  wire logic        sfr_wr_i,
    input  wire logic        sfr_rd_i,
    input  wire logic [7:0]  sfr_wdata_i,
    output logic      [7:0]  sfr_rdata_o,
    output logic             irq_o,
    output logic             wake_o,
    output logic      [15:0] wake_vector_o
);
    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    logic        xtal_tick;
    logic [7:0]  ctrl_ff;
    logic [7:0]  match_ff;
    logic [7:0]  icnt_ff;
    logic [7:0]  hth_sw_ff;
    logic [7:0]  sec_sw_ff;
    logic [7:0]  min_sw_ff;
    logic [7:0]  hour_sw_ff;
    logic        pend_ff;
    logic [7:0]  pend_addr_ff;
    logic [7:0]  pend_data_ff;
    logic        wr_apply;
    logic        ctrl_wr;
    logic [7:0]  hth;
    logic [7:0]  sec;
    logic [7:0]  min;
    logic [7:0]  hour;
    logic [3:0]  ovf;
    logic        tap;
    logic        advance;
    logic [7:0]  nxt_icnt;
    logic        match_set;
    logic        flag;
    logic        ien;
    logic        one_shot;
    timebase_t   tbsel;

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a >= `TIC_CTRL_ADDR) && (a <= `TIC_MATCH_ADDR);
    endfunction

    // ---------------------------------------------------------------
    // crystal edge and time base
    // ---------------------------------------------------------------
    // crystal arrives as a pin; every time step rides its rising edges
    xtal_sync u_sync (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .pin_i   (xtal_i),
        .rise_o  (xtal_tick)
    );

    // chain is gated by clock enable, power-down has no say
    time_base #(.PRESCALE(PRESCALE)) u_base (
        .clock_i     (clock_i),
        .rst_i       (rst_i),
        .tick_i      (xtal_tick),
        .run_i       (ctrl_ff[`TIC_CLKEN_BIT]),
        .hour24_i    (ctrl_ff[`TIC_HOUR24_BIT]),
        .load_hth_i  (hth_sw_ff),
        .load_sec_i  (sec_sw_ff),
        .load_min_i  (min_sw_ff),
        .load_hour_i (hour_sw_ff),
        .hth_o       (hth),
        .sec_o       (sec),
        .min_o       (min),
        .hour_o      (hour),
        .ovf_o       (ovf)
    );

    // ---------------------------------------------------------------
    // register writes, held until the next crystal edge
    // ---------------------------------------------------------------
    // a second write before the edge replaces the first
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            pend_ff      <= 1'b0;
            pend_addr_ff <= 8'h00;
            pend_data_ff <= 8'h00;
        end else if (sfr_wr_i && is_mapped(sfr_addr_i)) begin
            pend_ff      <= 1'b1;
            pend_addr_ff <= sfr_addr_i;
            pend_data_ff <= sfr_wdata_i;
        end else if (xtal_tick) begin
            pend_ff <= 1'b0;
        end
    end

    assign wr_apply = pend_ff && xtal_tick;
    assign ctrl_wr  = wr_apply && (pend_addr_ff == `TIC_CTRL_ADDR);

    assign flag     = ctrl_ff[`TIC_FLAG_BIT];
    assign ien      = ctrl_ff[`TIC_IEN_BIT];
    assign one_shot = ctrl_ff[`TIC_ONESHOT_BIT];
    assign tbsel    = timebase_t'(ctrl_ff[`TIC_TBSEL_HI:`TIC_TBSEL_LO]);

    // match value, any of 0..255
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            match_ff <= `TIC_MATCH_RESET;
        end else if (wr_apply && pend_addr_ff == `TIC_MATCH_ADDR) begin
            match_ff <= pend_data_ff;
        end
    end

    // software time values; accepted only while stopped
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            hth_sw_ff  <= `TIC_TIME_RESET;
            sec_sw_ff  <= `TIC_TIME_RESET;
            min_sw_ff  <= `TIC_TIME_RESET;
            hour_sw_ff <= `TIC_TIME_RESET;
        end else if (wr_apply && !ctrl_ff[`TIC_CLKEN_BIT]) begin
            unique case (pend_addr_ff)
                `TIC_HTH_ADDR:  hth_sw_ff  <= pend_data_ff;
                `TIC_SEC_ADDR:  sec_sw_ff  <= pend_data_ff;
                `TIC_MIN_ADDR:  min_sw_ff  <= pend_data_ff;
                `TIC_HOUR_ADDR: hour_sw_ff <= pend_data_ff;
                default: ;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // interval counter
    // ---------------------------------------------------------------
    // tap choice spans one tick up to hours
    always_comb begin
        unique case (tbsel)
            TB_SUBSEC: tap = ovf[0];
            TB_SEC:    tap = ovf[1];
            TB_MIN:    tap = ovf[2];
            TB_HOUR:   tap = ovf[3];
        endcase
    end

    assign advance   = ien && tap;
    assign nxt_icnt  = icnt_ff + 8'h01;
    assign match_set = advance && (nxt_icnt == match_ff);

    // disabled counter sits at zero so a new run starts clean
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            icnt_ff <= 8'h00;
        end else if (!ien) begin
            icnt_ff <= 8'h00;
        end else if (match_set) begin
            icnt_ff <= 8'h00;
        end else if (advance) begin
            icnt_ff <= nxt_icnt;
        end
    end

    // ---------------------------------------------------------------
    // control register
    // ---------------------------------------------------------------
    // hardware set and one-shot clear win over a same-edge write
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            ctrl_ff <= `TIC_CTRL_RESET;
        end else begin
            if (ctrl_wr) begin
                ctrl_ff <= pend_data_ff & `TIC_CTRL_WMASK;
            end
            if (match_set) begin
                ctrl_ff[`TIC_FLAG_BIT] <= 1'b1;
                if (one_shot) begin
                    ctrl_ff[`TIC_IEN_BIT] <= 1'b0;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // requests to the core and read data
    // ---------------------------------------------------------------
    // registered so the core sees a clean level
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            irq_o         <= 1'b0;
            wake_o        <= 1'b0;
            wake_vector_o <= 16'h0000;
        end else begin
            irq_o         <= flag && int_enable_i;
            wake_o        <= flag && int_enable_i && power_down_i;
            wake_vector_o <= `TIC_WAKE_VECTOR;
        end
    end

    // read mux; time registers show the live counts
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            sfr_rdata_o <= 8'h00;
        end else if (sfr_rd_i) begin
            unique case (sfr_addr_i)
                `TIC_CTRL_ADDR:  sfr_rdata_o <= ctrl_ff & `TIC_CTRL_WMASK;
                `TIC_HTH_ADDR:   sfr_rdata_o <= hth;
                `TIC_SEC_ADDR:   sfr_rdata_o <= sec;
                `TIC_MIN_ADDR:   sfr_rdata_o <= min;
                `TIC_HOUR_ADDR:  sfr_rdata_o <= hour;
                `TIC_MATCH_ADDR: sfr_rdata_o <= match_ff;
                default:         sfr_rdata_o <= 8'h00;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    a_flag_on_match: assert property (
        match_set |=> flag ##1 (irq_o == $past(int_enable_i)))
        else $error("match did not set flag");

    a_flag_sticky: assert property (
        flag && !(ctrl_wr && !pend_data_ff[`TIC_FLAG_BIT]) |=> flag)
        else $error("flag dropped without software clear");

    a_oneshot_clear: assert property (
        match_set && one_shot |=> !ien && icnt_ff == 8'h00)
        else $error("one-shot did not stop counter");

    a_reload_zero: assert property (
        match_set && !one_shot && !ctrl_wr |=> ien && icnt_ff == 8'h00)
        else $error("auto reload did not restart at zero");

    a_irq_level: assert property (
        flag && int_enable_i |=> irq_o)
        else $error("interrupt request missing");

    a_wake_pd: assert property (
        flag && int_enable_i && power_down_i |=>
            wake_o && wake_vector_o == 16'h0053)
        else $error("wake not raised in power-down");

    a_reserved_zero: assert property (
        sfr_rd_i && sfr_addr_i == `TIC_CTRL_ADDR |=> !sfr_rdata_o[7])
        else $error("reserved control bit read as one");

    a_write_waits: assert property (
        pend_ff && !xtal_tick && !sfr_wr_i |=>
            pend_ff && $stable(ctrl_ff) && $stable(match_ff))
        else $error("register write applied off crystal edge");

    a_counter_idle: assert property (
        !ien |=> icnt_ff == 8'h00)
        else $error("disabled counter moved");

    a_hour_limit: assert property (
        ctrl_ff[`TIC_HOUR24_BIT] && ctrl_ff[`TIC_CLKEN_BIT] &&
            hour <= 8'h17 |=> hour <= 8'h17)
        else $error("hour passed 23 in 24 hour mode");

    a_hour_wrap: assert property (
        ctrl_ff[`TIC_HOUR24_BIT] && ovf[3] && hour == `TIC_HOUR24_MAX |=>
            hour == 8'h00)
        else $error("hour did not wrap after 23");

    // a stopped chain must mirror the software copies, not hold counts
    a_time_frozen: assert property (
        !ctrl_ff[`TIC_CLKEN_BIT] |=>
            hth == $past(hth_sw_ff) && hour == $past(hour_sw_ff))
        else $error("stopped time registers not restored");

    a_wake_gated: assert property (
        !power_down_i |=> !wake_o)
        else $error("wake raised outside power-down");

    c_match_auto: cover property (match_set && !one_shot);
    c_match_once: cover property (match_set && one_shot);
    c_wake: cover property (wake_o);
    c_hour_wrap: cover property (ovf[3] && ctrl_ff[`TIC_HOUR24_BIT]);
endmodule // long_interval_timer

`default_nettype wire

// >>> tb/cpu_model.sv
`timescale 1ns/1ns
`default_nettype none

// ---------------------------------------------------------------
// cpu side of the special function register bus
// ---------------------------------------------------------------
module cpu_model (
    input  wire logic       clock_i,
    input  wire logic [7:0] sfr_rdata_i,
    output logic      [7:0] sfr_addr_o,
    output logic            sfr_wr_o,
    output logic            sfr_rd_o,
    output logic      [7:0] sfr_wdata_o
);
    // bus idle at time zero
    initial begin
        sfr_addr_o  = 8'h00;
        sfr_wr_o    = 1'b0;
        sfr_rd_o    = 1'b0;
        sfr_wdata_o = 8'h00;
    end

    // one-cycle write strobe, then 30 cycles (a crystal period and a half) of quiet so the
    // write lands before anything relies on it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        sfr_addr_o  <= a;
        sfr_wdata_o <= d;
        sfr_wr_o    <= 1'b1;
        @(posedge clock_i);
        sfr_wr_o    <= 1'b0;
        sfr_addr_o  <= ~a;
        sfr_wdata_o <= ~d;
        repeat (30) @(posedge clock_i);
    endtask

    // one-cycle read strobe, data taken once settled
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_i);
        sfr_addr_o <= a;
        sfr_rd_o   <= 1'b1;
        @(posedge clock_i);
        sfr_rd_o   <= 1'b0;
        sfr_addr_o <= ~a;
        @(posedge clock_i);
        @(negedge clock_i);
        d = sfr_rdata_i;
    endtask
endmodule // cpu_model

`default_nettype wire

// >>> tb/long_interval_timer_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "tic_regs.svh"

module long_interval_timer_tb;
    logic        clock_i;
    logic        rst_i;
    logic        xtal_i;
    logic        power_down_i;
    logic        int_enable_i;
    logic [7:0]  sfr_addr_i;
    logic        sfr_wr_i;
    logic        sfr_rd_i;
    logic [7:0]  sfr_wdata_i;
    logic [7:0]  sfr_rdata_o;
    logic        irq_o;
    logic        wake_o;
    logic [15:0] wake_vector_o;
    int          fail_count;
    int          comparisons;
    int          cyc;
    int          seed;
    int          t0;
    int          t1;
    logic [7:0]  d;
    logic [7:0]  m;

    // sub-second tick shortened to two crystal periods
    long_interval_timer #(.PRESCALE(2)) u_long_interval_timer (
        .clock_i(clock_i), .rst_i(rst_i), .xtal_i(xtal_i),
        .power_down_i(power_down_i), .int_enable_i(int_enable_i),
        .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
        .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
        .sfr_rdata_o(sfr_rdata_o), .irq_o(irq_o), .wake_o(wake_o),
        .wake_vector_o(wake_vector_o));

    cpu_model u_cpu_model (
        .clock_i(clock_i), .sfr_rdata_i(sfr_rdata_o),
        .sfr_addr_o(sfr_addr_i), .sfr_wr_o(sfr_wr_i),
        .sfr_rd_o(sfr_rd_i), .sfr_wdata_o(sfr_wdata_i));

    // core clock and a free crystal, crystal sped up to 20 core
    // cycles so that a run stays short
    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end
    initial begin
        xtal_i = 1'b0;
        #7;
        forever #400 xtal_i = ~xtal_i;
    end

    // cycle count and hang guard
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fail_count++;
            $display("[ERR] %0t run took too long", $time);
            conclude();
        end
    end

    function automatic logic [15:0] ticks_of(input int dt);
        return 16'((dt + 20) / 40);
    endfunction

    function automatic logic [7:0] step(input logic [7:0] v,
                                        input logic [7:0] top);
        return (v == top) ? 8'h00 : v + 8'h01;
    endfunction

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // bounded wait for the request line, sampled off the edge
    task automatic wait_irq(input int lim, output int t);
        int n;
        n = 0;
        @(negedge clock_i);
        while (irq_o !== 1'b1 && n < lim) begin
            @(negedge clock_i);
            n++;
        end
        t = cyc;
        if (n >= lim) begin
            fail_count++;
            $display("[ERR] %0t no interrupt request", $time);
        end
    endtask

    task automatic conclude();
        $display("compares %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        seed = 32'h2fa6010b;
        fail_count = 0;
        comparisons = 0;
        rst_i = 1'b1;
        power_down_i = 1'b0;
        int_enable_i = 1'b0;
        repeat (10) @(posedge clock_i);
        rst_i <= 1'b0;

        // reset values, reserved bit, unmapped place, match readback
        for (int a = 8'ha1; a <= 8'ha7; a++) begin
            u_cpu_model.rd(8'(a), d);
            check(16'(d), 16'h0000);
        end
        u_cpu_model.wr(`TIC_CTRL_ADDR, 8'h80);
        u_cpu_model.rd(`TIC_CTRL_ADDR, d);
        check(16'(d), 16'h0000);
        for (int i = 0; i < 3; i++) begin
            m = 8'($random(seed));
            u_cpu_model.wr(`TIC_MATCH_ADDR, m);
            u_cpu_model.rd(`TIC_MATCH_ADDR, d);
            check(16'(d), 16'(m));
        end
        $display("test registers done");

        // preload near rollover, run through carries, then stop
        u_cpu_model.wr(`TIC_HTH_ADDR, 8'h7e);
        u_cpu_model.wr(`TIC_SEC_ADDR, `TIC_SEC_MAX);
        u_cpu_model.rd(`TIC_SEC_ADDR, d);
        check(16'(d), 16'(`TIC_SEC_MAX));
        u_cpu_model.wr(`TIC_CTRL_ADDR, 8'h01);
        // refused while running; the stop below must bring back 3b
        u_cpu_model.wr(`TIC_SEC_ADDR, 8'h05);
        repeat (100) @(posedge clock_i);
        u_cpu_model.rd(`TIC_SEC_ADDR, d);
        check(16'(d), 16'(step(`TIC_SEC_MAX, `TIC_SEC_MAX)));
        u_cpu_model.rd(`TIC_MIN_ADDR, d);
        check(16'(d), 16'(step(8'h00, `TIC_MIN_MAX)));
        u_cpu_model.rd(`TIC_HTH_ADDR, d);
        check(16'(d < 8'h7e), 16'h0001);
        u_cpu_model.wr(`TIC_CTRL_ADDR, 8'h00);
        u_cpu_model.rd(`TIC_HTH_ADDR, d);
        check(16'(d), 16'h007e);
        u_cpu_model.rd(`TIC_SEC_ADDR, d);
        check(16'(d), 16'(`TIC_SEC_MAX));
        $display("test time base done");

        // auto reload: flag, request, spacing, masking, wake
        m = 8'h02 + 8'($random(seed) & 3);
        u_cpu_model.wr(`TIC_MATCH_ADDR, m);
        int_enable_i <= 1'b1;
        u_cpu_model.wr(`TIC_CTRL_ADDR, 8'h03);
        wait_irq(2000, t0);
        u_cpu_model.rd(`TIC_CTRL_ADDR, d);
        check(16'(d), 16'h0007);
        u_cpu_model.wr(`TIC_CTRL_ADDR, 8'h03);
        check(16'(irq_o), 16'h0000);
        wait_irq(2000, t1);
        check(ticks_of(t1 - t0), 16'(m));
        int_enable_i <= 1'b0;
        repeat (3 * 40 * int'(m)) @(posedge clock_i);
        check(16'(irq_o), 16'h0000);
        u_cpu_model.rd(`TIC_CTRL_ADDR, d);
        check(16'(d[2]), 16'h0001);
        @(posedge clock_i);
        power_down_i <= 1'b1;
        int_enable_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        @(negedge clock_i);
        check(16'(wake_o), 16'h0001);
        check(wake_vector_o, `TIC_WAKE_VECTOR);
        power_down_i <= 1'b0;
        $display("test auto reload done");

        // one shot: enable drops at timeout, counter then stays idle
        // stop the counter before the flag clear so no match races it
        u_cpu_model.wr(`TIC_CTRL_ADDR, 8'h05);
        u_cpu_model.wr(`TIC_CTRL_ADDR, 8'h09);
        u_cpu_model.wr(`TIC_CTRL_ADDR, 8'h0b);
        wait_irq(2000, t0);
        u_cpu_model.rd(`TIC_CTRL_ADDR, d);
        check(16'(d), 16'h000d);
        u_cpu_model.wr(`TIC_CTRL_ADDR, 8'h09);
        repeat (3 * 40 * int'(m)) @(posedge clock_i);
        check(16'(irq_o), 16'h0000);
        $display("test one shot done");

        // seconds tap from a zeroed sub-second count
        u_cpu_model.wr(`TIC_CTRL_ADDR, 8'h00);
        u_cpu_model.wr(`TIC_HTH_ADDR, 8'h00);
        u_cpu_model.wr(`TIC_MATCH_ADDR, 8'h01);
        t0 = cyc;
        u_cpu_model.wr(`TIC_CTRL_ADDR, 8'h13);
        wait_irq(7000, t1);
        check(16'(ticks_of(t1 - t0) >= 16'd127 &&
                  ticks_of(t1 - t0) <= 16'd130), 16'h0001);
        $display("test seconds tap done");

        // hour rollover in both hour modes via the hour and minute
        // taps; the second pass runs in power-down
        for (int i = 0; i < 2; i++) begin
            u_cpu_model.wr(`TIC_CTRL_ADDR, 8'h00);
            u_cpu_model.wr(`TIC_HTH_ADDR, `TIC_HTH_MAX);
            u_cpu_model.wr(`TIC_SEC_ADDR, `TIC_SEC_MAX);
            u_cpu_model.wr(`TIC_MIN_ADDR, `TIC_MIN_MAX);
            u_cpu_model.wr(`TIC_HOUR_ADDR, `TIC_HOUR24_MAX);
            power_down_i <= 1'(i);
            u_cpu_model.wr(`TIC_CTRL_ADDR, (i == 0) ? 8'h73 : 8'h23);
            wait_irq(2000, t1);
            check(16'(wake_o), 16'(i));
            u_cpu_model.rd(`TIC_HOUR_ADDR, d);
            m = step(`TIC_HOUR24_MAX, (i == 0) ? `TIC_HOUR24_MAX
                                               : `TIC_HOUR_FULL_MAX);
            check(16'(d), 16'(m));
        end
        $display("test hour rollover done");
        conclude();
    end
endmodule // long_interval_timer_tb

`default_nettype wire
